// ### rtl/bbs_cost.sv
module bbs_cost (
  bbs_exec_if.table_side cost
);
  localparam int CYC_W_SUM = bbs_pkg::CYC_W;

  logic [bbs_pkg::CYC_W-1:0] base_cycles;
  logic [bbs_pkg::CYC_W-1:0] bit_cycles;
  logic [bbs_pkg::CYC_W-1:0] seg_cycles;
  logic long_form;

  assign long_form = (cost.form == bbs_pkg::FORM_SHORT_DIRECT) ||
    (cost.form == bbs_pkg::FORM_SFR) || (cost.form == bbs_pkg::FORM_FLAG_REG) ||
    (cost.form == bbs_pkg::FORM_EXTRA_SEG_POINTER);
  // Only the pointer forms can reach program memory
  assign bit_cycles = (cost.in_prog_mem && cost.form == bbs_pkg::FORM_POINTER_PAIR) ?
    (cost.taken ? bbs_pkg::CYC_BIT_PM_T : bbs_pkg::CYC_BIT_PM_NT) :
    (cost.taken ? bbs_pkg::CYC_BIT_T : bbs_pkg::CYC_BIT_NT);
  assign seg_cycles = cost.in_prog_mem ?
    (cost.taken ? bbs_pkg::CYC_SEG_PM_T : bbs_pkg::CYC_SEG_PM_NT) :
    (cost.taken ? bbs_pkg::CYC_SEG_T : bbs_pkg::CYC_SEG_NT);

  always_comb
  begin
    cost.bytes = bbs_pkg::LEN_NOP;
    base_cycles = bbs_pkg::CYC_NOP;
    case (cost.op)
      bbs_pkg::OP_BRANCH_IF_BIT_CLEAR, bbs_pkg::OP_BRANCH_IF_SET_THEN_CLEAR:
      begin
        cost.bytes = long_form ? bbs_pkg::LEN_LONG_BIT : bbs_pkg::LEN_SHORT_BIT;
        base_cycles = (cost.form == bbs_pkg::FORM_EXTRA_SEG_POINTER) ?
          seg_cycles : bit_cycles;
      end
      bbs_pkg::OP_SKIP_ON_CARRY_SET, bbs_pkg::OP_SKIP_ON_CARRY_CLEAR,
      bbs_pkg::OP_SKIP_ON_ZERO_SET, bbs_pkg::OP_SKIP_ON_ZERO_CLEAR,
      bbs_pkg::OP_SKIP_IF_HIGHER, bbs_pkg::OP_SKIP_IF_NOT_HIGHER:
      begin
        cost.bytes = bbs_pkg::LEN_SKIP;
        base_cycles = bbs_pkg::CYC_SKIP;
      end
      bbs_pkg::OP_INTERRUPT_ENABLE_INSTR, bbs_pkg::OP_INTERRUPT_DISABLE_INSTR:
      begin
        cost.bytes = bbs_pkg::LEN_IRQ_CTRL;
        base_cycles = bbs_pkg::CYC_IRQ_CTRL;
      end
      bbs_pkg::OP_HALT, bbs_pkg::OP_STOP:
      begin
        cost.bytes = bbs_pkg::LEN_STANDBY;
        base_cycles = bbs_pkg::CYC_STANDBY;
      end
      default:
      begin
        cost.bytes = bbs_pkg::LEN_NOP;
        base_cycles = bbs_pkg::CYC_NOP;
      end
    endcase
    // Fetch from RAM charges the worst case, twice plus three
    cost.cycles = cost.ram_fetch ?
      (CYC_W_SUM'({base_cycles, 1'b0}) + bbs_pkg::CYC_RAM_FETCH_EXTRA) :
      base_cycles;
  end
endmodule : bbs_cost

// ### rtl/bbs_exec.sv
// Local design decisions: the address-and-strobe port and the register addresses.
module bbs_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction issue from the decoder
  input wire logic issue,
  input wire bbs_pkg::bbs_op_t issue_op,
  input wire bbs_pkg::bbs_form_t issue_form,
  input wire logic [2:0] issue_bit,
  input wire logic [7:0] issue_disp,
  input wire logic [bbs_pkg::PC_W-1:0] issue_addr,
  input wire logic [7:0] operand_byte,
  input wire logic operand_in_prog_mem,
  input wire logic fetch_from_ram,
  // Flag load from the data path
  input wire logic flag_load,
  input wire logic [7:0] flag_in,
  // Standby wake
  input wire logic wake,
  // Execution results
  output logic busy,
  output logic done,
  output logic [bbs_pkg::PC_W-1:0] next_pc,
  output logic skip_next,
  output logic suppressed,
  output logic bit_wr_en,
  output bbs_pkg::bbs_form_t bit_wr_form,
  output logic [7:0] bit_wr_data,
  output logic [7:0] flag_register,
  output logic global_irq_enable_flag,
  output logic halt_req,
  output logic stop_req,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data
);
  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} bbs_state_t;

  bbs_state_t state;
  bbs_state_t next_state;
  bbs_exec_if ex ();

  logic [7:0] ctrl;
  logic [bbs_pkg::CYC_W-1:0] last_cycles;
  logic pending_bit_wr;
  logic bit_value;
  logic [7:0] cleared_byte;
  logic flag_z;
  logic flag_cy;
  logic z_or_cy;
  logic is_bit_op;
  logic is_skip_op;
  logic cond_true;
  logic branch_taken;
  logic clears_bit;
  logic accept;
  logic do_suppress;
  logic [bbs_pkg::PC_W-1:0] disp_ext;
  logic [bbs_pkg::PC_W-1:0] seq_pc;
  logic [bbs_pkg::PC_W-1:0] next_pc_value;
  logic [7:0] next_flags;
  logic [7:0] rd_mux;
  logic [7:0] status_byte;
  logic [7:0] last_byte;
  logic [bbs_pkg::PC_W-1:0] target_pc;
  logic ctrl_wr;
  logic flags_wr;
  logic sel_ctrl;
  logic sel_status;
  logic sel_last;
  logic sel_flags;
  logic flag_form;
  logic op_bf;
  logic op_branch_if_set_then_clear;
  logic op_enable;
  logic op_disable;
  logic pend_set;
  logic retire;
  logic halt_retire;
  logic stop_retire;
  bbs_pkg::bbs_op_t ex_op_q;

  // One cost table serves every form, so lengths and counts live in one place
  bbs_cost u_cost (
    .cost (ex)
  );

  // Loaded at the taking edge; it alone decides how long the instruction lasts
  bbs_wait_counter #(
    .CNT_W (bbs_pkg::CYC_W)
  ) u_wait (
    .clk (clk),
    .reset (reset),
    .cnt (ex)
  );

  // Issue while busy, the done cycle included, is dropped without notice
  assign accept = issue && (state == ST_IDLE);
  // A skipped instruction is dropped whole and costs one cycle, or five on a stretched RAM fetch
  assign do_suppress = accept && skip_next;

  // Skip conditions read the registered flags, never the incoming load
  assign flag_z = flag_register[bbs_pkg::FLAG_Z_BIT];
  assign flag_cy = flag_register[bbs_pkg::FLAG_CY_BIT];
  assign z_or_cy = flag_z | flag_cy;

  // Opcode decode, one named wire per instruction that needs it
  assign flag_form = (issue_form == bbs_pkg::FORM_FLAG_REG);
  assign op_bf = (issue_op == bbs_pkg::OP_BRANCH_IF_BIT_CLEAR);
  assign op_branch_if_set_then_clear = (issue_op == bbs_pkg::OP_BRANCH_IF_SET_THEN_CLEAR);
  assign op_enable = (issue_op == bbs_pkg::OP_INTERRUPT_ENABLE_INSTR);
  assign op_disable = (issue_op == bbs_pkg::OP_INTERRUPT_DISABLE_INSTR);
  // The flag form reads the live flag register, not the operand bus
  assign bit_value = flag_form ? flag_register[issue_bit] : operand_byte[issue_bit];
  assign is_bit_op = op_bf || op_branch_if_set_then_clear;
  assign is_skip_op = (issue_op == bbs_pkg::OP_SKIP_ON_CARRY_SET) ||
    (issue_op == bbs_pkg::OP_SKIP_ON_CARRY_CLEAR) ||
    (issue_op == bbs_pkg::OP_SKIP_ON_ZERO_SET) ||
    (issue_op == bbs_pkg::OP_SKIP_ON_ZERO_CLEAR) ||
    (issue_op == bbs_pkg::OP_SKIP_IF_HIGHER) ||
    (issue_op == bbs_pkg::OP_SKIP_IF_NOT_HIGHER);

  // True when the instruction acts: the branch is taken or the next one skipped
  always_comb
  begin
    case (issue_op)
      bbs_pkg::OP_BRANCH_IF_BIT_CLEAR: cond_true = !bit_value;
      bbs_pkg::OP_BRANCH_IF_SET_THEN_CLEAR: cond_true = bit_value;
      bbs_pkg::OP_SKIP_ON_CARRY_SET: cond_true = flag_cy;
      bbs_pkg::OP_SKIP_ON_CARRY_CLEAR: cond_true = !flag_cy;
      bbs_pkg::OP_SKIP_ON_ZERO_SET: cond_true = flag_z;
      bbs_pkg::OP_SKIP_ON_ZERO_CLEAR: cond_true = !flag_z;
      bbs_pkg::OP_SKIP_IF_HIGHER: cond_true = !z_or_cy;
      bbs_pkg::OP_SKIP_IF_NOT_HIGHER: cond_true = z_or_cy;
      default: cond_true = 1'b0;
    endcase
  end

  assign branch_taken = is_bit_op && cond_true && !skip_next;
  assign clears_bit = branch_taken && op_branch_if_set_then_clear;
  assign pend_set = clears_bit && !flag_form;

  // Cost table inputs; taken also selects the longer cycle figure
  // A suppressed instruction is charged as a no-op
  assign ex.op = do_suppress ? bbs_pkg::OP_NOP : issue_op;
  assign ex.form = issue_form;
  assign ex.taken = branch_taken;
  assign ex.in_prog_mem = operand_in_prog_mem;
  assign ex.ram_fetch = fetch_from_ram && ctrl[bbs_pkg::CTRL_RAM_STRETCH_BIT];
  assign ex.load = accept;

  // Target is the address after the whole instruction plus the signed offset
  assign disp_ext = {{(bbs_pkg::PC_W - 8){issue_disp[7]}}, issue_disp};
  // The table length is used, so every form agrees with its own byte count
  assign seq_pc = issue_addr + bbs_pkg::PC_W'(ex.bytes);
  assign target_pc = seq_pc + disp_ext;
  assign next_pc_value = branch_taken ? target_pc : seq_pc;

  assign cleared_byte = operand_byte & ~(8'h01 << issue_bit);

  // Loads come first and the instruction's own flag effects go on top,
  // so a data path load in the same cycle as an issue is not lost
  always_comb
  begin
    next_flags = flag_register;
    if (flag_load)
      next_flags = flag_in;
    else if (flags_wr)
      next_flags = reg_wr_data;
    if (accept && !do_suppress)
    begin
      if (clears_bit && flag_form)
        next_flags[issue_bit] = 1'b0;
      if (op_enable)
        next_flags[bbs_pkg::FLAG_IE_BIT] = 1'b1;
      if (op_disable)
        next_flags[bbs_pkg::FLAG_IE_BIT] = 1'b0;
    end
  end

  // Two states suffice: the wait counter carries each instruction's length
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (accept) next_state = ST_EXEC;
      ST_EXEC: if (ex.expired) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  assign busy = (state == ST_EXEC);
  assign done = (state == ST_EXEC) && ex.expired;
  assign global_irq_enable_flag = flag_register[bbs_pkg::FLAG_IE_BIT];
  // Data path writes the cleared byte back once the instruction retires
  assign bit_wr_en = pending_bit_wr && done;

  // Standby entry only counts for an instruction that really ran
  assign retire = done && !suppressed;
  assign halt_retire = retire && (ex_op_q == bbs_pkg::OP_HALT);
  assign stop_retire = retire && (ex_op_q == bbs_pkg::OP_STOP);

  // Reset mid-instruction drops it whole; the counter restarts with it
  always_ff @(posedge clk)
  begin
    if (reset)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Live flag copy; skips and flag-form tests read it directly
  always_ff @(posedge clk)
  begin
    if (reset)
      flag_register <= bbs_pkg::FLAG_RESET;
    else
      flag_register <= next_flags;
  end

  // Results are taken at the accepting edge and stand until the next one
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      next_pc <= '0;
      suppressed <= 1'b0;
      last_cycles <= '0;
    end
    else if (accept)
    begin
      next_pc <= next_pc_value;
      suppressed <= do_suppress;
      last_cycles <= ex.cycles;
    end
  end

  // Skip flag lives for exactly one following instruction
  always_ff @(posedge clk)
  begin
    if (reset)
      skip_next <= 1'b0;
    else if (accept)
      skip_next <= !do_suppress && is_skip_op && cond_true;
  end

  // Branch-and-clear on any bit outside the flag register hands the cleared byte to the data path;
  // the byte is captured at the accepting edge, before the data path moves on
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pending_bit_wr <= 1'b0;
      bit_wr_form <= bbs_pkg::FORM_SHORT_DIRECT;
      bit_wr_data <= 8'h00;
    end
    else if (accept)
    begin
      pending_bit_wr <= pend_set;
      bit_wr_form <= issue_form;
      bit_wr_data <= cleared_byte;
    end
  end

  // Standby requests stay up until the wake event; wake wins over entry
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      halt_req <= 1'b0;
      stop_req <= 1'b0;
    end
    else if (wake)
    begin
      halt_req <= 1'b0;
      stop_req <= 1'b0;
    end
    else if (retire)
    begin
      halt_req <= halt_req || halt_retire;
      stop_req <= stop_req || stop_retire;
    end
  end

  // The running instruction is kept so that standby entry waits for its last cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      ex_op_q <= bbs_pkg::OP_NOP;
    else if (accept)
      ex_op_q <= issue_op;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      ctrl <= bbs_pkg::CTRL_RESET;
    // Only the stretch bit is kept; the rest read back as zero
    else if (ctrl_wr)
      ctrl <= {7'h00, reg_wr_data[bbs_pkg::CTRL_RAM_STRETCH_BIT]};
  end

  // Register port decode; unmapped addresses select nothing and read as zero
  assign ctrl_wr = reg_wr && (reg_addr == bbs_pkg::REG_CTRL);
  assign flags_wr = reg_wr && (reg_addr == bbs_pkg::REG_FLAGS);
  assign sel_ctrl = (reg_addr == bbs_pkg::REG_CTRL);
  assign sel_status = (reg_addr == bbs_pkg::REG_STATUS);
  assign sel_last = (reg_addr == bbs_pkg::REG_LAST_CYCLES);
  assign sel_flags = (reg_addr == bbs_pkg::REG_FLAGS);
  assign status_byte = {3'h0, skip_next, stop_req, halt_req, global_irq_enable_flag, busy};
  assign last_byte = {3'h0, last_cycles};
  // Selects are one-hot, so an AND-OR tree does the selection
  assign rd_mux = ({8{sel_ctrl}} & ctrl) | ({8{sel_status}} & status_byte) |
    ({8{sel_last}} & last_byte) | ({8{sel_flags}} & flag_register);

  // Read data stand for one cycle and fall back to zero, so nothing stale is seen
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rd_data <= 8'h00;
    else if (reg_rd)
      reg_rd_data <= rd_mux;
    else
      reg_rd_data <= 8'h00;
  end
endmodule : bbs_exec

// ### rtl/bbs_exec_if.sv
interface bbs_exec_if;
  bbs_pkg::bbs_op_t op;
  bbs_pkg::bbs_form_t form;
  logic taken;
  logic in_prog_mem;
  logic ram_fetch;
  logic [2:0] bytes;
  logic [bbs_pkg::CYC_W-1:0] cycles;
  logic load;
  logic expired;

  modport ctrl (output op, form, taken, in_prog_mem, ram_fetch, load,
    input bytes, cycles, expired);
  modport table_side (input op, form, taken, in_prog_mem, ram_fetch, output bytes, cycles);
  modport counter (input load, cycles, output expired);
endinterface : bbs_exec_if

// ### rtl/bbs_pkg.sv
package bbs_pkg;

  typedef enum logic [3:0] {
    OP_NOP, OP_INTERRUPT_ENABLE_INSTR, OP_INTERRUPT_DISABLE_INSTR, OP_HALT, OP_STOP,
    OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_IF_SET_THEN_CLEAR,
    OP_SKIP_ON_CARRY_SET, OP_SKIP_ON_CARRY_CLEAR, OP_SKIP_ON_ZERO_SET,
    OP_SKIP_ON_ZERO_CLEAR, OP_SKIP_IF_HIGHER, OP_SKIP_IF_NOT_HIGHER
  } bbs_op_t;

  typedef enum logic [2:0] {
    FORM_SHORT_DIRECT, FORM_SFR, FORM_ACC, FORM_FLAG_REG, FORM_POINTER_PAIR,
    FORM_EXTRA_SEG_POINTER
  } bbs_form_t;

  localparam int PC_W = 20;
  localparam int CYC_W = 5;

  // Instruction lengths in bytes
  localparam logic [2:0] LEN_LONG_BIT = 3'h4;
  localparam logic [2:0] LEN_SHORT_BIT = 3'h3;
  localparam logic [2:0] LEN_SKIP = 3'h2;
  localparam logic [2:0] LEN_NOP = 3'h1;
  localparam logic [2:0] LEN_IRQ_CTRL = 3'h3;
  localparam logic [2:0] LEN_STANDBY = 3'h2;

  // Cycle counts, first figure falls through, second is taken
  localparam logic [CYC_W-1:0] CYC_BIT_NT = 5'h3;
  localparam logic [CYC_W-1:0] CYC_BIT_T = 5'h5;
  localparam logic [CYC_W-1:0] CYC_BIT_PM_NT = 5'h6;
  localparam logic [CYC_W-1:0] CYC_BIT_PM_T = 5'h7;
  localparam logic [CYC_W-1:0] CYC_SEG_NT = 5'h4;
  localparam logic [CYC_W-1:0] CYC_SEG_T = 5'h6;
  localparam logic [CYC_W-1:0] CYC_SEG_PM_NT = 5'h7;
  localparam logic [CYC_W-1:0] CYC_SEG_PM_T = 5'h8;
  localparam logic [CYC_W-1:0] CYC_SKIP = 5'h1;
  localparam logic [CYC_W-1:0] CYC_NOP = 5'h1;
  localparam logic [CYC_W-1:0] CYC_IRQ_CTRL = 5'h4;
  localparam logic [CYC_W-1:0] CYC_STANDBY = 5'h3;
  localparam logic [CYC_W-1:0] CYC_RAM_FETCH_EXTRA = 5'h3;
  localparam logic [CYC_W-1:0] CYC_SUPPRESSED = 5'h1;

  // Flag register bit positions
  localparam int FLAG_IE_BIT = 7;
  localparam int FLAG_Z_BIT = 6;
  localparam int FLAG_AC_BIT = 4;
  localparam int FLAG_CY_BIT = 0;
  localparam logic [7:0] FLAG_RESET = 8'h06;

  // Register port map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LAST_CYCLES = 4'h8;
  localparam logic [3:0] REG_FLAGS = 4'hc;
  localparam int CTRL_RAM_STRETCH_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h01;

endpackage : bbs_pkg

// ### rtl/bbs_wait_counter.sv
module bbs_wait_counter #(
  parameter int CNT_W = bbs_pkg::CYC_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Load and expiry
  bbs_exec_if.counter cnt
);
  logic [CNT_W-1:0] remaining;

  // Expires in the last cycle of the charged count
  assign cnt.expired = (remaining == CNT_W'(1));

  always_ff @(posedge clk)
  begin
    if (reset)
      remaining <= '0;
    else if (cnt.load)
      remaining <= CNT_W'(cnt.cycles);
    else if (remaining != '0)
      remaining <= remaining - CNT_W'(1);
  end
endmodule : bbs_wait_counter

// ### tb/bbs_exec_chk.sv
module bbs_exec_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic issue,
  input wire bbs_pkg::bbs_op_t issue_op,
  input wire bbs_pkg::bbs_form_t issue_form,
  input wire logic [2:0] issue_bit,
  input wire logic [7:0] operand_byte,
  input wire logic operand_in_prog_mem,
  input wire logic [bbs_pkg::PC_W-1:0] issue_addr,
  input wire logic fetch_from_ram,
  input wire logic busy,
  input wire logic done,
  input wire logic [bbs_pkg::PC_W-1:0] next_pc,
  input wire logic skip_next,
  input wire logic suppressed,
  input wire logic bit_wr_en,
  input wire logic [7:0] flag_register,
  input wire logic global_irq_enable_flag,
  input wire logic halt_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // Only unstretched fetches, so the listed counts apply exactly
  wire take = issue && !busy && !skip_next && !fetch_from_ram;
  wire drop = issue && !busy && skip_next && !fetch_from_ram;
  chk_nop_single_cycle:
    assert property (take && issue_op == bbs_pkg::OP_NOP |=> done ##1 !busy)
    else $error("nop count wrong");
  chk_enable_four_cycles:
    assert property (take && issue_op == bbs_pkg::OP_INTERRUPT_ENABLE_INSTR
      |=> !done [*3] ##1 (done && global_irq_enable_flag)) else $error("enable wrong");
  chk_disable_four_cycles:
    assert property (take && issue_op == bbs_pkg::OP_INTERRUPT_DISABLE_INSTR
      |=> ##3 (done && !global_irq_enable_flag)) else $error("disable wrong");
  chk_skip_length:
    assert property (take && issue_op >= bbs_pkg::OP_SKIP_ON_CARRY_SET
      |=> done && next_pc == $past(issue_addr) + 20'h2) else $error("skip length wrong");
  chk_carry_skip:
    assert property (take && issue_op == bbs_pkg::OP_SKIP_ON_CARRY_SET
      |=> skip_next == $past(flag_register[0])) else $error("carry skip wrong");
  chk_higher_skip:
    assert property (take && issue_op == bbs_pkg::OP_SKIP_IF_HIGHER
      |=> skip_next == !($past(flag_register[6]) || $past(flag_register[0])))
    else $error("higher skip wrong");
  chk_drop_next:
    assert property (drop |=> done && suppressed && !skip_next) else $error("drop wrong");
  chk_write_at_done:
    assert property (bit_wr_en |-> done) else $error("bit write off done");
  // A taken clear on a data-area byte writes back in its fifth and last cycle
  chk_clear_write_back:
    assert property (take && issue_op == bbs_pkg::OP_BRANCH_IF_SET_THEN_CLEAR &&
      issue_form != bbs_pkg::FORM_FLAG_REG && issue_form != bbs_pkg::FORM_EXTRA_SEG_POINTER &&
      !operand_in_prog_mem && operand_byte[issue_bit]
      |=> !bit_wr_en [*4] ##1 (done && bit_wr_en)) else $error("clear write wrong");
  chk_halt_at_done:
    assert property ($rose(halt_req) |-> $past(done)) else $error("halt set early");
  cover property (bit_wr_en);
  cover property (drop);
  cover property ($rose(halt_req));
endmodule : bbs_exec_chk

bind bbs_exec bbs_exec_chk u_chk (
  .clk (clk), .reset (reset), .issue (issue), .issue_op (issue_op),
  .issue_form (issue_form), .issue_bit (issue_bit), .operand_byte (operand_byte),
  .operand_in_prog_mem (operand_in_prog_mem), .issue_addr (issue_addr),
  .fetch_from_ram (fetch_from_ram), .busy (busy), .done (done), .next_pc (next_pc),
  .skip_next (skip_next), .suppressed (suppressed), .bit_wr_en (bit_wr_en),
  .flag_register (flag_register), .global_irq_enable_flag (global_irq_enable_flag),
  .halt_req (halt_req)
);

// ### tb/bbs_mem_model.sv
module bbs_mem_model (
  // Clock
  input wire logic clk,
  // Operand read and write back
  input wire logic issue,
  input wire logic busy,
  input wire logic [bbs_pkg::PC_W-1:0] issue_addr,
  input wire logic bit_wr_en,
  input wire logic [7:0] bit_wr_data,
  output logic [7:0] operand_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [16];
  logic [3:0] wr_idx;
  // Every byte starts with bit 0 clear and bit 1 set
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'haa;
  end
  assign operand_byte = mem[issue_addr[3:0]];
  // The clear lands in the byte that the accepted instruction read
  always @(posedge clk)
  begin
    if (issue && !busy)
      wr_idx <= issue_addr[3:0];
    if (bit_wr_en)
      mem[wr_idx] <= bit_wr_data;
  end
endmodule : bbs_mem_model

// ### tb/bit_branch_skip_cpu_control_test.sv
module bit_branch_skip_cpu_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, issue, operand_in_prog_mem, fetch_from_ram, flag_load, wake;
  logic reg_wr, reg_rd, busy, done, skip_next, suppressed, bit_wr_en, wr_seen;
  logic global_irq_enable_flag, halt_req, stop_req;
  bbs_pkg::bbs_op_t issue_op;
  bbs_pkg::bbs_form_t issue_form, bit_wr_form;
  logic [2:0] issue_bit;
  logic [3:0] reg_addr;
  logic [7:0] issue_disp, operand_byte, flag_in, reg_wr_data, reg_rd_data;
  logic [7:0] bit_wr_data, flag_register;
  logic [bbs_pkg::PC_W-1:0] issue_addr, next_pc;
  int error_cnt, n_compared;

  bbs_exec u_dut (
    .clk (clk), .reset (reset), .issue (issue), .issue_op (issue_op),
    .issue_form (issue_form), .issue_bit (issue_bit), .issue_disp (issue_disp),
    .issue_addr (issue_addr), .operand_byte (operand_byte),
    .operand_in_prog_mem (operand_in_prog_mem), .fetch_from_ram (fetch_from_ram),
    .flag_load (flag_load), .flag_in (flag_in), .wake (wake), .busy (busy), .done (done),
    .next_pc (next_pc), .skip_next (skip_next), .suppressed (suppressed),
    .bit_wr_en (bit_wr_en), .bit_wr_form (bit_wr_form), .bit_wr_data (bit_wr_data),
    .flag_register (flag_register), .global_irq_enable_flag (global_irq_enable_flag),
    .halt_req (halt_req), .stop_req (stop_req), .reg_addr (reg_addr),
    .reg_wr_data (reg_wr_data), .reg_wr (reg_wr), .reg_rd (reg_rd),
    .reg_rd_data (reg_rd_data)
  );
  bbs_mem_model u_mem (
    .clk (clk), .issue (issue), .busy (busy), .issue_addr (issue_addr),
    .bit_wr_en (bit_wr_en), .bit_wr_data (bit_wr_data), .operand_byte (operand_byte)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Op and form are enum positions; counts cycles from the taking edge to done
  task automatic run(input int op, input int fm, input int b, input int a, input int cyc);
    int n;
    @(posedge clk);
    issue_op <= bbs_pkg::bbs_op_t'(op);
    issue_form <= bbs_pkg::bbs_form_t'(fm);
    issue_bit <= 3'(b);
    issue_addr <= 20'(a);
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    n = 1;
    #1;
    while (done !== 1'b1 && n < 30)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 30)
    begin
      error_cnt++;
      close_out();
    end
    wr_seen = bit_wr_en;
    check(20'(n), 20'(cyc));
  endtask : run

  task automatic load_flags(input logic [7:0] v);
    @(posedge clk);
    flag_load <= 1'b1;
    flag_in <= v;
    @(posedge clk);
    flag_load <= 1'b0;
  endtask : load_flags

  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!wr)
      check(20'(reg_rd_data), 20'(d));
  endtask : reg_op

  task automatic wake_up;
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1;
  endtask : wake_up

  task automatic s_regs;
    reg_op(1'b0, bbs_pkg::REG_CTRL, 8'h01);
    reg_op(1'b0, bbs_pkg::REG_FLAGS, 8'h06);
    reg_op(1'b1, 4'h2, 8'hff);
    reg_op(1'b0, 4'h2, 8'h00);
    reg_op(1'b1, bbs_pkg::REG_FLAGS, 8'h05);
    reg_op(1'b0, bbs_pkg::REG_FLAGS, 8'h05);
    reg_op(1'b1, bbs_pkg::REG_FLAGS, 8'h06);
  endtask : s_regs

  task automatic s_bf;
    int len [6] = '{4, 4, 3, 4, 3, 4};
    for (int i = 0; i < 6; i++)
    begin
      run(5, i, 0, 'h01000, (i == 5) ? 6 : 5);
      check(next_pc, 20'(32'h01000 + len[i] - 16));
      run(5, i, 1, 'h01000, (i == 5) ? 4 : 3);
      check(next_pc, 20'(32'h01000 + len[i]));
    end
  endtask : s_bf

  task automatic s_pm;
    @(posedge clk);
    operand_in_prog_mem <= 1'b1;
    run(5, 4, 0, 'h01000, 7);
    run(5, 4, 1, 'h01000, 6);
    run(5, 5, 0, 'h01000, 8);
    run(5, 5, 1, 'h01000, 7);
    run(5, 0, 0, 'h01000, 5);
    operand_in_prog_mem <= 1'b0;
  endtask : s_pm

  task automatic s_branch_if_set_then_clear;
    run(6, 2, 1, 'h02004, 5);
    check(wr_seen, 1'b1);
    check(bit_wr_data, 8'ha8);
    check(bit_wr_form, 20'(bbs_pkg::FORM_ACC));
    check(next_pc, 20'h01ff7);
    run(6, 2, 1, 'h02004, 3);
    check(wr_seen, 1'b0);
    run(6, 5, 3, 'h02005, 6);
    check(next_pc, 20'h01ff9);
    run(6, 3, 2, 'h02006, 5);
    check(flag_register, 8'h02);
  endtask : s_branch_if_set_then_clear

  task automatic s_skip;
    logic [7:0] fl [3] = '{8'h00, 8'h01, 8'h40};
    logic [5:0] sel;
    for (int j = 0; j < 3; j++)
      for (int i = 7; i < 13; i++)
      begin
        load_flags(fl[j]);
        sel = {fl[j][6] | fl[j][0], !(fl[j][6] | fl[j][0]), !fl[j][6], fl[j][6],
          !fl[j][0], fl[j][0]};
        run(i, 0, 0, 'h03000, 1);
        check(next_pc, 20'h03002);
        check(skip_next, sel[i-7]);
        run(0, 0, 0, 'h03002, 1);
        check(suppressed, sel[i-7]);
      end
  endtask : s_skip

  task automatic s_cpu;
    run(1, 0, 0, 'h04000, 4);
    check(global_irq_enable_flag, 1'b1);
    check(next_pc, 20'h04003);
    run(2, 0, 0, 'h04000, 4);
    check(global_irq_enable_flag, 1'b0);
    run(3, 0, 0, 'h04000, 3);
    // The standby request is registered at the edge that ends the done cycle
    @(posedge clk);
    #1;
    check(halt_req, 1'b1);
    check(next_pc, 20'h04002);
    reg_op(1'b0, bbs_pkg::REG_STATUS, 8'h04);
    wake_up;
    run(4, 0, 0, 'h04000, 3);
    @(posedge clk);
    #1;
    check(stop_req, 1'b1);
    wake_up;
    run(0, 0, 0, 'h04000, 1);
    check(next_pc, 20'h04001);
  endtask : s_cpu

  task automatic s_ram;
    @(posedge clk);
    fetch_from_ram <= 1'b1;
    run(0, 0, 0, 'h05000, 5);
    run(1, 0, 0, 'h05000, 11);
    reg_op(1'b0, bbs_pkg::REG_LAST_CYCLES, 8'h0b);
    reg_op(1'b1, bbs_pkg::REG_CTRL, 8'h00);
    run(0, 0, 0, 'h05000, 1);
    fetch_from_ram <= 1'b0;
  endtask : s_ram

  initial
  begin
    reset = 1'b1;
    {issue, operand_in_prog_mem, fetch_from_ram, flag_load, wake, reg_wr, reg_rd} = '0;
    issue_op = bbs_pkg::OP_NOP;
    issue_form = bbs_pkg::FORM_SHORT_DIRECT;
    issue_bit = 3'h0;
    issue_addr = '0;
    issue_disp = 8'hf0;
    {flag_in, reg_wr_data} = '0;
    reg_addr = 4'h0;
    error_cnt = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    s_regs;
    s_bf;
    s_pm;
    s_branch_if_set_then_clear;
    s_skip;
    s_cpu;
    s_ram;
    close_out;
  end
endmodule : bit_branch_skip_cpu_control_test
